// ### logic/epo_top.sv
// Energy pulse outputs: parameter registers, power selection and two switched outputs
// Behaviour
// - Two independent switched digital outputs, each assignable to a function.
// - Per-output source selector at 200 and 202; code 2 selects external value.
// - Code 0 routes comparator group one to output one, group two to two.
// - Output states readable at 608 and 609: 0 off, 1 conducting.
// - Pulse output emits one pulse each time the set energy quantum accumulates.
// - Power quantity per pulse output chosen by selectors at 100 and 101.
// - One pulse length setting at 106 applies to both pulse outputs.
// - Pulse length 10 ms to 10 s; gap between pulses exceeds 10 ms.
// - After each pulse, pause at least the pulse length, else as energy requires.
// - Never more than one pulse per pulse-plus-pause period.
// - Energy per pulse set per output by pulse value at 102 and 104.
// - Positive pulse value pulses only while the selected power is positive.
// - Negative pulse value pulses only while the selected power is negative.
// - Pulse rate proportional to measured power within the settings.
`timescale 1ns/1ps
module epo_top
    import epo_pkg::*;
#(
    parameter int unsigned CYC_MS = CYC_PER_MS,
    parameter int unsigned NPWR = N_PWR
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire epo_par_req_t par_req_i,
    input wire logic [NPWR-1:0][31:0] pwr_i,
    input wire logic [N_OUT-1:0] cmp_grp_i,
    input wire logic [N_OUT-1:0] ext_val_i,
    output logic [15:0] par_rdata_o,
    output logic par_rvalid_o,
    output logic par_err_o,
    output logic [N_OUT-1:0] dout_o
);

    epo_top_state_t s_ff;
    epo_top_state_t nxt_s;
    epo_reg_t ridx;
    logic [N_OUT-1:0] pulse;
    logic [31:0] len_cyc;

    // Address decode shared by reads and writes
    function automatic epo_reg_t reg_of(input logic [15:0] a);
        epo_reg_t r;
        r = R_NONE;
        case (a)
            ADR_PWR_SEL_A: r = R_PSA;
            ADR_PWR_SEL_B: r = R_PSB;
            ADR_PV_A_HI: r = R_PVA_H;
            ADR_PV_A_LO: r = R_PVA_L;
            ADR_PV_B_HI: r = R_PVB_H;
            ADR_PV_B_LO: r = R_PVB_L;
            ADR_PLEN: r = R_PLEN;
            ADR_SRC_ONE: r = R_SRC1;
            ADR_SRC_TWO: r = R_SRC2;
            ADR_STATE_ONE: r = R_ST1;
            ADR_STATE_TWO: r = R_ST2;
            default: r = R_NONE;
        endcase
        return r;
    endfunction

    // Pulse length limited to the allowed span
    function automatic logic [15:0] clamp_len(input logic [15:0] v);
        logic [15:0] r;
        r = v;
        if (v < PLEN_MIN_MS) begin
            r = PLEN_MIN_MS;
        end else if (v > PLEN_MAX_MS) begin
            r = PLEN_MAX_MS;
        end
        return r;
    endfunction

    // Selected power; an index out of range gives zero power
    function automatic logic signed [31:0] pick_pwr(input logic [NPWR-1:0][31:0] p, input logic [15:0] sel);
        logic signed [31:0] r;
        r = '0;
        for (int i = 0; i < NPWR; i++) begin
            if (sel == 16'(i)) begin
                r = p[i];
            end
        end
        return r;
    endfunction

    assign ridx = reg_of(par_req_i.addr);
    assign len_cyc = 32'(32'(s_ff.plen) * 32'(CYC_MS));

    always_comb begin
        nxt_s = s_ff;
        nxt_s.rvalid = 1'b0;
        nxt_s.err = 1'b0;
        // Millisecond time base for energy integration
        if (s_ff.ms_cnt == 32'(CYC_MS - 1)) begin
            nxt_s.ms_cnt = '0;
            nxt_s.ms_tick = 1'b1;
        end else begin
            nxt_s.ms_cnt = s_ff.ms_cnt + 32'h0000_0001;
            nxt_s.ms_tick = 1'b0;
        end
        // Parameter writes
        if (par_req_i.wr) begin
            case (ridx)
                R_PSA: nxt_s.pwr_sel[0] = par_req_i.wdata;
                R_PSB: nxt_s.pwr_sel[1] = par_req_i.wdata;
                R_PVA_H: nxt_s.pv[0][31:16] = par_req_i.wdata;
                R_PVA_L: nxt_s.pv[0][15:0] = par_req_i.wdata;
                R_PVB_H: nxt_s.pv[1][31:16] = par_req_i.wdata;
                R_PVB_L: nxt_s.pv[1][15:0] = par_req_i.wdata;
                R_PLEN: nxt_s.plen = clamp_len(par_req_i.wdata);
                R_SRC1: nxt_s.src[0] = par_req_i.wdata;
                R_SRC2: nxt_s.src[1] = par_req_i.wdata;
                default: nxt_s.err = 1'b1;
            endcase
        end
        // Parameter reads
        if (par_req_i.rd) begin
            nxt_s.rvalid = 1'b1;
            case (ridx)
                R_PSA: nxt_s.rdata = s_ff.pwr_sel[0];
                R_PSB: nxt_s.rdata = s_ff.pwr_sel[1];
                R_PVA_H: nxt_s.rdata = s_ff.pv[0][31:16];
                R_PVA_L: nxt_s.rdata = s_ff.pv[0][15:0];
                R_PVB_H: nxt_s.rdata = s_ff.pv[1][31:16];
                R_PVB_L: nxt_s.rdata = s_ff.pv[1][15:0];
                R_PLEN: nxt_s.rdata = s_ff.plen;
                R_SRC1: nxt_s.rdata = s_ff.src[0];
                R_SRC2: nxt_s.rdata = s_ff.src[1];
                R_ST1: nxt_s.rdata = {15'h0000, dout_o[0]};
                R_ST2: nxt_s.rdata = {15'h0000, dout_o[1]};
                default: begin
                    nxt_s.rdata = 16'h0000;
                    nxt_s.err = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s_ff.pwr_sel <= {RST_PWR_SEL, RST_PWR_SEL};
            s_ff.pv <= {RST_PV, RST_PV};
            s_ff.plen <= RST_PLEN;
            s_ff.src <= {RST_SRC, RST_SRC};
            s_ff.ms_cnt <= '0;
            s_ff.ms_tick <= 1'b0;
            s_ff.rdata <= 16'h0000;
            s_ff.rvalid <= 1'b0;
            s_ff.err <= 1'b0;
        end else if (ce_i) begin
            s_ff <= nxt_s;
        end
    end

    // One pulse generator and one source selector per output
    for (genvar g = 0; g < N_OUT; g++) begin : g_out
        epo_pulse_gen u_pg (
            .clk_i(clk_i),
            .rst_n_i(rst_n_i),
            .ce_i(ce_i),
            .ms_tick_i(s_ff.ms_tick),
            .pwr_i(pick_pwr(pwr_i, s_ff.pwr_sel[g])),
            .cfg_i('{pv: s_ff.pv[g], len_cyc: len_cyc}),
            .pulse_o(pulse[g])
        );
        epo_out_sel u_sel (
            .clk_i(clk_i),
            .rst_n_i(rst_n_i),
            .ce_i(ce_i),
            .src_i(s_ff.src[g]),
            .cmp_i(cmp_grp_i[g]),
            .pulse_i(pulse[g]),
            .ext_i(ext_val_i[g]),
            .dout_o(dout_o[g])
        );
    end

    assign par_rdata_o = s_ff.rdata;
    assign par_rvalid_o = s_ff.rvalid;
    assign par_err_o = s_ff.err;

endmodule

// ### logic/epo_pkg.sv
// Package: constants, register map and carrier types of the energy pulse outputs
package epo_pkg;

    localparam int unsigned N_OUT = 2;
    localparam int unsigned N_PWR = 8;

    // Parameter addresses, 16-bit words; 32-bit values take two words, high word first
    localparam logic [15:0] ADR_PWR_SEL_A = 16'h0064;
    localparam logic [15:0] ADR_PWR_SEL_B = 16'h0065;
    localparam logic [15:0] ADR_PV_A_HI = 16'h0066;
    localparam logic [15:0] ADR_PV_A_LO = 16'h0067;
    localparam logic [15:0] ADR_PV_B_HI = 16'h0068;
    localparam logic [15:0] ADR_PV_B_LO = 16'h0069;
    localparam logic [15:0] ADR_PLEN = 16'h006A;
    localparam logic [15:0] ADR_SRC_ONE = 16'h00C8;
    localparam logic [15:0] ADR_SRC_TWO = 16'h00CA;
    localparam logic [15:0] ADR_STATE_ONE = 16'h0260;
    localparam logic [15:0] ADR_STATE_TWO = 16'h0261;

    // Values after reset
    localparam logic [15:0] RST_PWR_SEL = 16'h0000;
    localparam logic [31:0] RST_PV = 32'h0000_0000;
    localparam logic [15:0] RST_PLEN = 16'h001E;
    localparam logic [15:0] RST_SRC = 16'h0000;

    // Source selector codes
    localparam logic [15:0] SRC_CODE_CMP = 16'h0000;
    localparam logic [15:0] SRC_CODE_PULSE = 16'h0001;
    localparam logic [15:0] SRC_CODE_EXT = 16'h0002;

    // Pulse length limits in ms
    localparam logic [15:0] PLEN_MIN_MS = 16'h000A;
    localparam logic [15:0] PLEN_MAX_MS = 16'h2710;

    // Timing: one ms in ns and the clock period in ns
    localparam int unsigned T_MS_NS = 1000000;
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned CYC_PER_MS = T_MS_NS / CLK_PERIOD_NS;

    // Energy units: accumulator in W*ms, pulse value in mWh
    localparam int unsigned WMS_PER_MWH = 3600;

    typedef enum logic [3:0] {
        R_NONE, R_PSA, R_PSB, R_PVA_H, R_PVA_L, R_PVB_H, R_PVB_L,
        R_PLEN, R_SRC1, R_SRC2, R_ST1, R_ST2
    } epo_reg_t;

    typedef enum logic [1:0] {PG_IDLE, PG_HIGH, PG_PAUSE} epo_pg_st_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [15:0] wdata;
    } epo_par_req_t;

    typedef struct packed {
        logic signed [31:0] pv;
        logic [31:0] len_cyc;
    } epo_pg_cfg_t;

    typedef struct packed {
        epo_pg_st_t st;
        logic signed [47:0] acc;
        logic [31:0] cnt;
        logic pulse;
    } epo_pg_state_t;

    typedef struct packed {
        logic dout;
    } epo_sel_state_t;

    typedef struct packed {
        logic [1:0][15:0] pwr_sel;
        logic [1:0][31:0] pv;
        logic [15:0] plen;
        logic [1:0][15:0] src;
        logic [31:0] ms_cnt;
        logic ms_tick;
        logic [15:0] rdata;
        logic rvalid;
        logic err;
    } epo_top_state_t;

endpackage

// ### logic/epo_pulse_gen.sv
// Energy pulse generator for one output: accumulator, pulse and pause timing
`timescale 1ns/1ps
module epo_pulse_gen
    import epo_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic ms_tick_i,
    input wire logic signed [31:0] pwr_i,
    input wire epo_pg_cfg_t cfg_i,
    output logic pulse_o
);

    epo_pg_state_t s_ff;
    epo_pg_state_t nxt_s;
    logic [31:0] mag;
    logic signed [47:0] thr;
    logic pos;
    logic neg;

    assign mag = cfg_i.pv[31] ? 32'(-cfg_i.pv) : 32'(cfg_i.pv);
    assign thr = 48'(48'(mag) * 48'(WMS_PER_MWH));
    assign pos = (cfg_i.pv > 0) && (pwr_i > 0);
    assign neg = (cfg_i.pv < 0) && (pwr_i < 0);

    always_comb begin
        nxt_s = s_ff;
        if (cfg_i.pv == 0) begin
            nxt_s.acc = '0;
        end else if (ms_tick_i && (pos || neg)) begin
            nxt_s.acc = s_ff.acc + 48'(pwr_i);
        end
        case (s_ff.st)
            PG_IDLE: begin
                if ((cfg_i.pv > 0 && nxt_s.acc >= thr) || (cfg_i.pv < 0 && nxt_s.acc <= -thr)) begin
                    nxt_s.acc = (cfg_i.pv > 0) ? nxt_s.acc - thr : nxt_s.acc + thr;
                    nxt_s.st = PG_HIGH;
                    nxt_s.cnt = cfg_i.len_cyc - 32'h0000_0001;
                end
            end
            PG_HIGH: begin
                if (s_ff.cnt == 32'h0000_0000) begin
                    nxt_s.st = PG_PAUSE;
                    nxt_s.cnt = cfg_i.len_cyc;
                end else begin
                    nxt_s.cnt = s_ff.cnt - 32'h0000_0001;
                end
            end
            PG_PAUSE: begin
                if (s_ff.cnt == 32'h0000_0000) begin
                    nxt_s.st = PG_IDLE;
                end else begin
                    nxt_s.cnt = s_ff.cnt - 32'h0000_0001;
                end
            end
            default: begin
                nxt_s.st = PG_IDLE;
            end
        endcase
        nxt_s.pulse = (nxt_s.st == PG_HIGH);
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s_ff <= '{st: PG_IDLE, acc: '0, cnt: '0, pulse: 1'b0};
        end else if (ce_i) begin
            s_ff <= nxt_s;
        end
    end

    assign pulse_o = s_ff.pulse;

endmodule

// ### logic/epo_out_sel.sv
// Source selector and output flop of one switched digital output
`timescale 1ns/1ps
module epo_out_sel
    import epo_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic [15:0] src_i,
    input wire logic cmp_i,
    input wire logic pulse_i,
    input wire logic ext_i,
    output logic dout_o
);

    epo_sel_state_t s_ff;
    epo_sel_state_t nxt_s;

    always_comb begin
        nxt_s = s_ff;
        case (src_i)
            SRC_CODE_CMP: begin
                nxt_s.dout = cmp_i;
            end
            SRC_CODE_PULSE: begin
                nxt_s.dout = pulse_i;
            end
            SRC_CODE_EXT: begin
                nxt_s.dout = ext_i;
            end
            default: begin
                nxt_s.dout = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s_ff <= '{dout: 1'b0};
        end else if (ce_i) begin
            s_ff <= nxt_s;
        end
    end

    assign dout_o = s_ff.dout;

endmodule

// ### test/epo_rx_model.sv
// Pulse receiver model: counts pulses and measures their width
`timescale 1ns/1ps
module epo_rx_model (
    input wire logic clk_i,
    input wire logic clr_i,
    input wire logic line_i,
    output int cnt_o,
    output int wid_o
);
    int run = 0;
    always @(posedge clk_i) begin
        if (clr_i)
            cnt_o <= 0;
        else if (line_i && run == 0)
            cnt_o <= cnt_o + 1;
        run <= line_i ? run + 1 : 0;
        if (!line_i && run != 0)
            wid_o <= run;
    end
endmodule

// ### test/epo_top_sva.sv
// Checker of the energy pulse outputs at the top ports
`timescale 1ns/1ps
module epo_top_sva
    import epo_pkg::*;
#(
    parameter int unsigned CYC_MS = 4,
    parameter int unsigned NPWR = 8
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire epo_par_req_t par_req_i,
    input wire logic [NPWR-1:0][31:0] pwr_i,
    input wire logic [N_OUT-1:0] cmp_grp_i,
    input wire logic [N_OUT-1:0] ext_val_i,
    input wire logic [15:0] par_rdata_o,
    input wire logic par_rvalid_o,
    input wire logic par_err_o,
    input wire logic [N_OUT-1:0] dout_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    logic [1:0][15:0] s;
    int hc;
    int lc;
    int hl;
    // Source mirrors of both outputs and high/low run counters of output one
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s <= '0;
            hc <= 0;
            lc <= 32'h0FFF_FFFF;
            hl <= 0;
        end else if (ce_i) begin
            if (par_req_i.wr && par_req_i.addr == ADR_SRC_ONE)
                s[0] <= par_req_i.wdata;
            if (par_req_i.wr && par_req_i.addr == ADR_SRC_TWO)
                s[1] <= par_req_i.wdata;
            hc <= dout_o[0] ? hc + 1 : 0;
            lc <= dout_o[0] ? 0 : lc + 1;
            if (!dout_o[0] && hc != 0)
                hl <= hc;
        end
    end
    property p_rv;
        ce_i && par_req_i.rd |=> par_rvalid_o;
    endproperty
    a_rv: assert property (p_rv) else $error("read not answered");
    property p_ro;
        ce_i && par_req_i.wr && par_req_i.addr == ADR_STATE_TWO |=> par_err_o;
    endproperty
    a_ro: assert property (p_ro) else $error("state write accepted");
    property p_unm;
        ce_i && par_req_i.rd && par_req_i.addr == 16'h0001 |=> par_err_o && par_rdata_o == 16'h0000;
    endproperty
    a_unm: assert property (p_unm) else $error("unmapped read");
    property p_st;
        ce_i && par_req_i.rd && par_req_i.addr == ADR_STATE_ONE |=> par_rdata_o == {15'h0000, $past(dout_o[0])};
    endproperty
    a_st: assert property (p_st) else $error("state readback");
    property p_cmp;
        ce_i && s[0] == SRC_CODE_CMP |=> dout_o[0] == $past(cmp_grp_i[0]);
    endproperty
    a_cmp: assert property (p_cmp) else $error("comparator route");
    property p_ext;
        ce_i && s[1] == SRC_CODE_EXT |=> dout_o[1] == $past(ext_val_i[1]);
    endproperty
    a_ext: assert property (p_ext) else $error("external route");
    property p_off;
        ce_i && s[0] > SRC_CODE_EXT |=> !dout_o[0];
    endproperty
    a_off: assert property (p_off) else $error("unknown source on");
    property p_pw;
        ce_i && $fell(dout_o[0]) && s[0] == SRC_CODE_PULSE |-> hc >= 10 * CYC_MS;
    endproperty
    a_pw: assert property (p_pw) else $error("pulse too short");
    property p_pause;
        ce_i && $rose(dout_o[0]) && s[0] == SRC_CODE_PULSE |-> lc > hl && lc > 10 * CYC_MS;
    endproperty
    a_pause: assert property (p_pause) else $error("pause too short");
endmodule

bind epo_top epo_top_sva #(.CYC_MS(CYC_MS), .NPWR(NPWR)) u_sva (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .par_req_i(par_req_i),
    .pwr_i(pwr_i),
    .cmp_grp_i(cmp_grp_i),
    .ext_val_i(ext_val_i),
    .par_rdata_o(par_rdata_o),
    .par_rvalid_o(par_rvalid_o),
    .par_err_o(par_err_o),
    .dout_o(dout_o)
);

// ### test/energy_pulse_output_test.sv
// Testbench of the energy pulse outputs with register model and receivers
`timescale 1ns/1ps
module energy_pulse_output_test
    import epo_pkg::*;
;
    localparam int CM = 4;
    localparam int LIM = 730 * CM / (20 * CM + 2);
    logic clk_i = 0;
    logic rst_n_i = 0;
    logic ce = 1;
    epo_par_req_t req = '0;
    logic [N_PWR-1:0][31:0] pwr = '0;
    logic [1:0] cmp = '0;
    logic [1:0] ext = '0;
    logic [15:0] rdata;
    logic rvalid;
    logic err;
    logic [1:0] dout;
    logic clr = 0;
    int cnt [2];
    int wid [2];
    int errors = 0;
    int n_checks = 0;
    int seed = 32'hA6AE8B4D;
    logic [15:0] m [logic [15:0]];
    logic [15:0] codes [3] = '{16'h0000, 16'h0003, 16'h0002};
    always #4 clk_i = ~clk_i;
    epo_top #(.CYC_MS(CM)) DUT (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce),
        .par_req_i(req),
        .pwr_i(pwr),
        .cmp_grp_i(cmp),
        .ext_val_i(ext),
        .par_rdata_o(rdata),
        .par_rvalid_o(rvalid),
        .par_err_o(err),
        .dout_o(dout)
    );
    epo_rx_model u_rx0 (.clk_i(clk_i), .clr_i(clr), .line_i(dout[0]), .cnt_o(cnt[0]), .wid_o(wid[0]));
    epo_rx_model u_rx1 (.clk_i(clk_i), .clr_i(clr), .line_i(dout[1]), .cnt_o(cnt[1]), .wid_o(wid[1]));
    task automatic summarize;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        n_checks++;
        if (s !== e) begin
            errors++;
            $display("[ERR] %s exp %0h got %0h", n, e, s);
        end
    endtask
    // One register access with model update and answer check
    task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d);
        logic ok;
        ok = m.exists(a) && (!w || a < ADR_STATE_ONE);
        @(posedge clk_i) req <= '{w, !w, a, d};
        @(posedge clk_i) req <= '0;
        @(posedge clk_i);
        chk("err", {31'h0, !ok}, {31'h0, err});
        if (!w) begin
            chk("rvalid", 1, {31'h0, rvalid});
            chk("rdata", ok ? m[a] : 16'h0000, {16'h0000, rdata});
        end else if (ok)
            m[a] = a != ADR_PLEN ? d : d < PLEN_MIN_MS ? PLEN_MIN_MS : d > PLEN_MAX_MS ? PLEN_MAX_MS : d;
    endtask
    task automatic pv(input logic [15:0] a, input logic [31:0] v);
        acc(1, a + 16'h0001, 16'h0000);
        acc(1, a, 16'h0000);
        acc(1, a, v[31:16]);
        acc(1, a + 16'h0001, v[15:0]);
    endtask
    function automatic int ex(int p, int v);
        if (v == 0 || p == 0 || (p < 0) != (v < 0))
            return 0;
        return 730 * (p < 0 ? -p : p) / (3600 * (v < 0 ? -v : v));
    endfunction
    // Pulse run of 730 ms on both outputs
    task automatic run(input int p0, input int p1, input int va, input int vb);
        int e0;
        int e1;
        e0 = ex(p0, va);
        e1 = ex(p1, vb);
        pwr[0] <= p0;
        pwr[1] <= p1;
        pv(ADR_PV_A_HI, va);
        pv(ADR_PV_B_HI, vb);
        clr <= 1;
        @(posedge clk_i) clr <= 0;
        repeat (730 * CM - 1) @(posedge clk_i);
        if (e0 > LIM)
            chk("cap", 1, {31'h0, cnt[0] >= LIM && cnt[0] <= LIM + 1});
        else
            chk("cnt0", e0, cnt[0]);
        chk("cnt1", e1, cnt[1]);
        if (e0 > 0)
            chk("wid0", 10 * CM, wid[0]);
        if (e1 > 0)
            chk("wid1", 10 * CM, wid[1]);
    endtask
    initial begin
        repeat (100000) @(posedge clk_i);
        errors++;
        summarize();
    end
    initial begin
        m[ADR_PWR_SEL_A] = RST_PWR_SEL;
        m[ADR_PWR_SEL_B] = RST_PWR_SEL;
        m[ADR_PV_A_HI] = RST_PV[31:16];
        m[ADR_PV_A_LO] = RST_PV[15:0];
        m[ADR_PV_B_HI] = RST_PV[31:16];
        m[ADR_PV_B_LO] = RST_PV[15:0];
        m[ADR_PLEN] = RST_PLEN;
        m[ADR_SRC_ONE] = RST_SRC;
        m[ADR_SRC_TWO] = RST_SRC;
        m[ADR_STATE_ONE] = 16'h0000;
        m[ADR_STATE_TWO] = 16'h0000;
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1;
        foreach (m[a])
            acc(0, a, 16'h0000);
        acc(0, 16'h0001, 16'h0000);
        acc(1, 16'h0001, 16'h0005);
        acc(1, ADR_STATE_TWO, 16'h0001);
        acc(1, ADR_PLEN, 16'h4E20);
        acc(0, ADR_PLEN, 16'h0000);
        acc(1, ADR_PLEN, 16'h0005);
        acc(0, ADR_PLEN, 16'h0000);
        foreach (codes[k]) begin
            acc(1, ADR_SRC_ONE, codes[k]);
            acc(1, ADR_SRC_TWO, codes[k]);
            repeat (6) begin
                @(posedge clk_i);
                cmp <= 2'($random(seed));
                ext <= 2'($random(seed));
                pwr[2] <= $random(seed);
                @(posedge clk_i);
                @(posedge clk_i);
                chk("dout", codes[k] == 0 ? cmp : codes[k] == 2 ? ext : 2'b00, {30'h0, dout});
            end
        end
        ext <= 2'b11;
        m[ADR_STATE_ONE] = 16'h0001;
        m[ADR_STATE_TWO] = 16'h0001;
        acc(0, ADR_STATE_ONE, 16'h0000);
        acc(0, ADR_STATE_TWO, 16'h0000);
        ext <= 2'b00;
        m[ADR_STATE_ONE] = 16'h0000;
        m[ADR_STATE_TWO] = 16'h0000;
        // Write while frozen is lost
        ce <= 1'b0;
        acc(1, ADR_PWR_SEL_A, 16'h0005);
        m[ADR_PWR_SEL_A] = RST_PWR_SEL;
        ce <= 1'b1;
        acc(0, ADR_PWR_SEL_A, 16'h0000);
        acc(1, ADR_PWR_SEL_B, 16'h0001);
        acc(1, ADR_SRC_ONE, SRC_CODE_PULSE);
        acc(1, ADR_SRC_TWO, SRC_CODE_PULSE);
        run(100, -50, 1, -1);
        run(-100, 50, 1, -1);
        run(10000, 0, 1, 1);
        summarize();
    end
endmodule
